//--- rtl/llc_regs.svh
/*
 * Offsets, bit positions, reset values and counts for the link-layer core
 * control register, upper half. Assumes a 32-bit byte-addressed register port.
 */
//
// Overview of operation
// [R1] Writing one to bit 31 resets the core except registers and timing; self-clears.
// [R2] Writing one to bit 30 resets only the timing generator; self-clears.
// [R3] Writing one to bit 29 resets the whole register block; self-clears.
// [R4] Writing one to bit 26 aborts the running radio test; self-clears.
// [R5] Infinite transmit abort finishes the current byte, then stops and closes the CRC.
// [R6] Infinite receive abort waits for packet end if synced, else stops with radio off.
// [R7] Writing one to bit 25 ends the current advertising event; self-clears.
// [R8] Writing one to bit 24 ends the current scan window; self-clears.
// [R9] Bit 22 set forces one transmit/receive exchange per event, ignoring more-data bits.
// [R10] Bit 21 set sends software sequence number and ignores the received one.
// [R11] Bit 20 set sends software next-sequence number and ignores the received one.
// [R12] Bit 19 set disables both encryption and decryption.
// [R13] With bit 19 set and structure encryption on, MIC stays, payload goes plain.
// [R14] Bit 18 set skips whitening and de-whitening.
// [R15] Bit 17 set keeps received CRC in stream and sends all-zero CRC.
// [R16] Bit 16 set bypasses the hop remapping algorithm.
// [R17] All bits reset to zero; reserved bits read zero and ignore writes.
`ifndef LLC_REGS_SVH
`define LLC_REGS_SVH

// ****************************************
// Register map
// ****************************************
`define LLC_CTRL_OFFSET 32'h4000_0000
`define LLC_CTRL_RESET 32'h0000_0000
`define LLC_CTRL_WR_MASK 32'he77f_0000

// ****************************************
// Field positions
// ****************************************
`define LLC_BIT_CORE_RST 31
`define LLC_BIT_TG_RST 30
`define LLC_BIT_REG_RST 29
`define LLC_BIT_TEST_ABORT 26
`define LLC_BIT_ADV_ABORT 25
`define LLC_BIT_SCAN_ABORT 24
`define LLC_BIT_MD 22
`define LLC_BIT_SN 21
`define LLC_BIT_NESN 20
`define LLC_BIT_CRYPT 19
`define LLC_BIT_WHIT 18
`define LLC_BIT_CRC 17
`define LLC_BIT_HOP 16

// ****************************************
// Timing
// ****************************************
`define LLC_SOFT_RST_CYCLES 4

`endif

//--- rtl/llc_pkg.sv
/*
 * Types shared by the link-layer core control block.
 * Assumes the constants header is included by each user.
 */
package llc_pkg;

	// Static disables, bit 22 down to 16
	typedef struct packed {
		logic more_data_override;
		logic seqnum_mgmt_disable;
		logic next_seqnum_mgmt_disable;
		logic encryption_disable;
		logic whitening_disable;
		logic crc_strip_disable;
		logic hop_remap_disable;
	} llc_ctrl_t;

	// What the radio test is doing when aborted
	typedef enum logic [1:0] {
		LLC_TEST_NONE,
		LLC_TEST_INF_TX,
		LLC_TEST_INF_RX
	} llc_test_kind_t;

	typedef enum logic [1:0] {
		LLC_TA_IDLE,
		LLC_TA_WAIT_BYTE,
		LLC_TA_WAIT_PKT
	} llc_ta_state_t;

	// Stop commands to the packet controller
	typedef struct packed {
		logic tx_stop_crc;
		logic rx_stop_pkt;
		logic rf_off;
	} llc_test_stop_t;

endpackage

//--- rtl/llc_test_abort.sv
/*
 * Sequences a radio-test abort against the packet controller's progress.
 * Assumes status inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "llc_regs.svh"

module llc_test_abort (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Request from the control register
	input wire logic i_abort_req,
	// Packet controller status
	input wire llc_pkg::llc_test_kind_t i_kind,
	input wire logic i_byte_done,
	input wire logic i_sync_found,
	input wire logic i_pkt_end,
	// Commands and completion
	output llc_pkg::llc_test_stop_t o_stop,
	output logic o_done
);
	import llc_pkg::*;

	llc_ta_state_t state_q;

	// ****************************************
	// Abort sequencer
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_q <= LLC_TA_IDLE;
			o_stop <= '0;
			o_done <= 1'b0;
		end else begin
			o_stop <= '0;
			o_done <= 1'b0;
			unique case (state_q)
				LLC_TA_IDLE: begin
					if (i_abort_req && !o_done) begin
						unique case (i_kind)
							LLC_TEST_INF_TX: begin
								state_q <= LLC_TA_WAIT_BYTE; // [R5]
							end
							LLC_TEST_INF_RX: begin
								if (i_sync_found) begin
									state_q <= LLC_TA_WAIT_PKT; // [R6]
								end else begin
									o_stop.rf_off <= 1'b1; // [R6]
									o_done <= 1'b1;
								end
							end
							default: begin
								// Nothing running, acknowledge at once
								o_done <= 1'b1; // [R4]
							end
						endcase
					end
				end
				LLC_TA_WAIT_BYTE: begin
					if (i_byte_done) begin
						o_stop.tx_stop_crc <= 1'b1; // [R5]
						o_done <= 1'b1;
						state_q <= LLC_TA_IDLE;
					end
				end
				LLC_TA_WAIT_PKT: begin
					if (i_pkt_end) begin
						o_stop.rx_stop_pkt <= 1'b1; // [R6]
						o_done <= 1'b1;
						state_q <= LLC_TA_IDLE;
					end
				end
				default: begin
					state_q <= LLC_TA_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	tx_byte_stop_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R5]
		(state_q == LLC_TA_WAIT_BYTE && i_byte_done) |=> o_stop.tx_stop_crc && o_done)
		else $error("tx abort did not stop at byte end");
	rx_nosync_off_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R6]
		(state_q == LLC_TA_IDLE && i_abort_req && !o_done && i_kind == LLC_TEST_INF_RX && !i_sync_found)
		|=> o_stop.rf_off)
		else $error("rx abort without sync did not switch radio off");

endmodule

//--- rtl/llc_ctrl.sv
/*
 * Upper half of the link-layer core control register: soft resets, activity
 * aborts and static datapath disables, on a plain strobe register port.
 * Assumes bus strobes and datapath status come from the same clock domain.
 */
`timescale 1ns/1ps
`include "llc_regs.svh"

module llc_ctrl #(
	parameter int RST_CYCLES = `LLC_SOFT_RST_CYCLES
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Register port
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Soft resets
	output logic o_core_soft_rst,
	output logic o_timing_gen_soft_reset,
	output logic o_reg_soft_rst,
	// Advertising and scan aborts
	output logic o_advertising_abort,
	input wire logic i_adv_abort_done,
	output logic o_scan_abort,
	input wire logic i_scan_abort_done,
	// Radio test abort
	input wire llc_pkg::llc_test_kind_t i_test_kind,
	input wire logic i_test_byte_done,
	input wire logic i_test_sync_found,
	input wire logic i_test_pkt_end,
	output llc_pkg::llc_test_stop_t o_test_stop,
	// Static controls
	output llc_pkg::llc_ctrl_t o_ctrl,
	// Sequence numbers
	input wire logic i_desc_sn,
	input wire logic i_desc_nesn,
	input wire logic i_auto_sn,
	input wire logic i_auto_nesn,
	output logic o_tx_sn,
	output logic o_tx_nesn,
	output logic o_sn_check_en,
	output logic o_nesn_check_en,
	// Encryption
	input wire logic i_ctrl_struct_encrypt_enable,
	output logic o_mic_enable,
	output logic o_payload_encrypt,
	output logic o_payload_decrypt,
	// Datapath enables
	output logic o_single_exchange,
	output logic o_whiten_en,
	output logic o_rx_crc_keep,
	output logic o_tx_crc_zero,
	output logic o_hop_remap_en
);
	import llc_pkg::*;

	localparam int CW = $clog2(RST_CYCLES + 1);

	// ****************************************
	// Helpers
	// ****************************************
	// Self-clearing bit: a fresh write of one beats the completion clear
	function automatic logic self_clear(input logic q, input logic set, input logic done);
		logic r;
		r = q;
		if (done) begin
			r = 1'b0;
		end
		if (set) begin
			r = 1'b1;
		end
		return r;
	endfunction

	function automatic logic [CW-1:0] cnt_next(input logic [CW-1:0] c, input logic start);
		logic [CW-1:0] r;
		r = c;
		if (start) begin
			r = CW'(RST_CYCLES);
		end else if (c != '0) begin
			r = c - CW'(1);
		end
		return r;
	endfunction

	logic hit;
	logic wr_hit;
	logic reg_rst_start;
	logic test_abort_q;
	logic test_done;
	logic [CW-1:0] core_cnt_q;
	logic [CW-1:0] tg_cnt_q;
	logic [CW-1:0] reg_cnt_q;
	logic [31:0] rd_word;

	assign hit = (i_addr == `LLC_CTRL_OFFSET);
	assign wr_hit = i_wr && hit;
	// [R3]
	assign reg_rst_start = wr_hit && i_wdata[`LLC_BIT_REG_RST];

	// ****************************************
	// Soft resets
	// ****************************************
	// Each reset is held a fixed count, then the bit drops by itself
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			core_cnt_q <= '0;
		end else begin
			core_cnt_q <= cnt_next(core_cnt_q, wr_hit && i_wdata[`LLC_BIT_CORE_RST] && core_cnt_q == '0); // [R1]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			tg_cnt_q <= '0;
		end else begin
			tg_cnt_q <= cnt_next(tg_cnt_q, wr_hit && i_wdata[`LLC_BIT_TG_RST] && tg_cnt_q == '0); // [R2]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			reg_cnt_q <= '0;
		end else begin
			reg_cnt_q <= cnt_next(reg_cnt_q, reg_rst_start && reg_cnt_q == '0); // [R3]
		end
	end

	// Outputs are the live bit values; zero writes never start a count
	assign o_core_soft_rst = (core_cnt_q != '0); // [R1]
	assign o_timing_gen_soft_reset = (tg_cnt_q != '0); // [R2]
	assign o_reg_soft_rst = (reg_cnt_q != '0); // [R3]

	// ****************************************
	// Activity aborts
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (i_rst || reg_rst_start) begin
			o_advertising_abort <= 1'b0;
		end else begin
			o_advertising_abort <= self_clear(o_advertising_abort,
				wr_hit && i_wdata[`LLC_BIT_ADV_ABORT], i_adv_abort_done); // [R7]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst || reg_rst_start) begin
			o_scan_abort <= 1'b0;
		end else begin
			o_scan_abort <= self_clear(o_scan_abort,
				wr_hit && i_wdata[`LLC_BIT_SCAN_ABORT], i_scan_abort_done); // [R8]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst || reg_rst_start) begin
			test_abort_q <= 1'b0;
		end else begin
			test_abort_q <= self_clear(test_abort_q,
				wr_hit && i_wdata[`LLC_BIT_TEST_ABORT], test_done); // [R4]
		end
	end

	llc_test_abort u_test_abort (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_abort_req(test_abort_q),
		.i_kind(i_test_kind),
		.i_byte_done(i_test_byte_done),
		.i_sync_found(i_test_sync_found),
		.i_pkt_end(i_test_pkt_end),
		.o_stop(o_test_stop),
		.o_done(test_done)
	);

	// ****************************************
	// Static controls
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (i_rst || reg_rst_start) begin
			o_ctrl <= '0; // [R17]
		end else if (wr_hit) begin
			o_ctrl <= i_wdata[`LLC_BIT_MD:`LLC_BIT_HOP];
		end
	end

	// ****************************************
	// Derived datapath controls
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_tx_sn <= 1'b0;
			o_sn_check_en <= 1'b0;
		end else begin
			o_tx_sn <= o_ctrl.seqnum_mgmt_disable ? i_desc_sn : i_auto_sn; // [R10]
			o_sn_check_en <= !o_ctrl.seqnum_mgmt_disable; // [R10]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_tx_nesn <= 1'b0;
			o_nesn_check_en <= 1'b0;
		end else begin
			o_tx_nesn <= o_ctrl.next_seqnum_mgmt_disable ? i_desc_nesn : i_auto_nesn; // [R11]
			o_nesn_check_en <= !o_ctrl.next_seqnum_mgmt_disable; // [R11]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_mic_enable <= 1'b0;
			o_payload_encrypt <= 1'b0;
			o_payload_decrypt <= 1'b0;
		end else begin
			// MIC survives the disable; only the payload goes plain
			o_mic_enable <= i_ctrl_struct_encrypt_enable; // [R13]
			o_payload_encrypt <= i_ctrl_struct_encrypt_enable && !o_ctrl.encryption_disable; // [R12]
			o_payload_decrypt <= i_ctrl_struct_encrypt_enable && !o_ctrl.encryption_disable; // [R12]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_single_exchange <= 1'b0;
			o_whiten_en <= 1'b0;
			o_rx_crc_keep <= 1'b0;
			o_tx_crc_zero <= 1'b0;
			o_hop_remap_en <= 1'b0;
		end else begin
			o_single_exchange <= o_ctrl.more_data_override; // [R9]
			o_whiten_en <= !o_ctrl.whitening_disable; // [R14]
			o_rx_crc_keep <= o_ctrl.crc_strip_disable; // [R15]
			o_tx_crc_zero <= o_ctrl.crc_strip_disable; // [R15]
			o_hop_remap_en <= !o_ctrl.hop_remap_disable; // [R16]
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		rd_word = '0; // [R17]
		rd_word[`LLC_BIT_CORE_RST] = o_core_soft_rst;
		rd_word[`LLC_BIT_TG_RST] = o_timing_gen_soft_reset;
		rd_word[`LLC_BIT_REG_RST] = o_reg_soft_rst;
		rd_word[`LLC_BIT_TEST_ABORT] = test_abort_q;
		rd_word[`LLC_BIT_ADV_ABORT] = o_advertising_abort;
		rd_word[`LLC_BIT_SCAN_ABORT] = o_scan_abort;
		rd_word[`LLC_BIT_MD:`LLC_BIT_HOP] = o_ctrl;
	end

	// Data stands for the one cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else if (i_rd && hit) begin
			o_rdata <= rd_word & `LLC_CTRL_WR_MASK;
		end else begin
			o_rdata <= '0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	core_rst_len_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R1]
		$rose(o_core_soft_rst) |-> o_core_soft_rst [*4] ##1 !o_core_soft_rst)
		else $error("core soft reset length wrong");
	core_zero_wr_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R1]
		(!o_core_soft_rst && wr_hit && !i_wdata[`LLC_BIT_CORE_RST]) |=> !o_core_soft_rst)
		else $error("zero write started core reset");
	tg_rst_len_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R2]
		$rose(o_timing_gen_soft_reset) |-> o_timing_gen_soft_reset [*4] ##1 !o_timing_gen_soft_reset)
		else $error("timing reset length wrong");
	reg_rst_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R3]
		reg_rst_start |=> o_ctrl == '0 && !o_scan_abort && !o_advertising_abort && o_reg_soft_rst)
		else $error("register reset did not clear block");
	test_abort_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R4]
		(test_abort_q && !test_done) |=> test_abort_q)
		else $error("test abort dropped early");
	adv_abort_set_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R7]
		(wr_hit && i_wdata[`LLC_BIT_ADV_ABORT] && !reg_rst_start) |=> o_advertising_abort)
		else $error("advertising abort lost");
	scan_abort_clr_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R8]
		(o_scan_abort && i_scan_abort_done && !(wr_hit && i_wdata[`LLC_BIT_SCAN_ABORT]))
		|=> !o_scan_abort)
		else $error("scan abort did not self clear");
	single_xchg_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R9]
		(wr_hit && !reg_rst_start) |=> ##1 o_single_exchange == $past(i_wdata[`LLC_BIT_MD], 2))
		else $error("single exchange control mismatch");
	sn_source_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R10]
		o_ctrl.seqnum_mgmt_disable |=> o_tx_sn == $past(i_desc_sn) && !o_sn_check_en)
		else $error("sequence number not from descriptor");
	nesn_source_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R11]
		o_ctrl.next_seqnum_mgmt_disable |=> o_tx_nesn == $past(i_desc_nesn) && !o_nesn_check_en)
		else $error("next sequence number not from descriptor");
	plain_payload_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R13]
		(o_ctrl.encryption_disable && i_ctrl_struct_encrypt_enable)
		|=> o_mic_enable && !o_payload_encrypt && !o_payload_decrypt)
		else $error("payload encrypted while disabled");
	whiten_ctrl_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R14]
		o_ctrl.whitening_disable |=> !o_whiten_en)
		else $error("whitening left on");
	crc_zero_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R15]
		(wr_hit && !reg_rst_start && i_wdata[`LLC_BIT_CRC]) |=> ##1 o_tx_crc_zero && o_rx_crc_keep)
		else $error("crc disable not applied");
	hop_ctrl_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R16]
		o_ctrl.hop_remap_disable |=> !o_hop_remap_en)
		else $error("hop remap left on");
	rsvd_read_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R17]
		1'b1 |=> (o_rdata & ~`LLC_CTRL_WR_MASK) == '0 && ($past(i_rd && hit) || o_rdata == '0))
		else $error("reserved or idle read data not zero");
	reg_rst_len_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R3]
		$rose(o_reg_soft_rst) |-> o_reg_soft_rst [*4] ##1 !o_reg_soft_rst)
		else $error("register reset length wrong");
	tg_zero_wr_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R2]
		(!o_timing_gen_soft_reset && wr_hit && !i_wdata[`LLC_BIT_TG_RST]) |=> !o_timing_gen_soft_reset)
		else $error("zero write started timing reset");
	adv_abort_clr_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R7]
		(o_advertising_abort && i_adv_abort_done && !(wr_hit && i_wdata[`LLC_BIT_ADV_ABORT]))
		|=> !o_advertising_abort)
		else $error("advertising abort did not self clear");
	scan_abort_set_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R8]
		(wr_hit && i_wdata[`LLC_BIT_SCAN_ABORT] && !reg_rst_start) |=> o_scan_abort)
		else $error("scan abort lost");
	test_abort_clr_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R4]
		(test_abort_q && test_done && !(wr_hit && i_wdata[`LLC_BIT_TEST_ABORT]))
		|=> !test_abort_q)
		else $error("test abort did not self clear");
	crypt_normal_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R12]
		(!o_ctrl.encryption_disable && i_ctrl_struct_encrypt_enable)
		|=> o_payload_encrypt && o_payload_decrypt)
		else $error("payload not encrypted in normal mode");

	core_rst_c: cover property (@(posedge i_mclk) disable iff (i_rst) $fell(o_core_soft_rst));
	reg_rst_c: cover property (@(posedge i_mclk) disable iff (i_rst) reg_rst_start);
	adv_race_c: cover property (@(posedge i_mclk) disable iff (i_rst)
		o_advertising_abort && i_adv_abort_done && wr_hit && i_wdata[`LLC_BIT_ADV_ABORT]);
	test_done_c: cover property (@(posedge i_mclk) disable iff (i_rst) test_done);

endmodule

//--- verif/test_link_layer_core_control.sv
/*
 * Self-checking bench for the upper control register half: reset state,
 * static disables, soft resets, activity aborts and radio-test abort.
 * Assumes the register header and llc_pkg are compiled alongside.
 */
`timescale 1ns/1ps
`include "llc_regs.svh"

module test_link_layer_core_control;
	import llc_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	localparam int LIMIT = 2000;
	localparam logic [31:0] OFF = `LLC_CTRL_OFFSET;
	logic i_mclk = 1'b0;
	logic i_rst, i_wr, i_rd, i_adv_abort_done, i_scan_abort_done;
	logic i_test_byte_done, i_test_sync_found, i_test_pkt_end;
	logic i_desc_sn, i_desc_nesn, i_auto_sn, i_auto_nesn, i_ctrl_struct_encrypt_enable;
	logic [31:0] i_addr, i_wdata, o_rdata;
	llc_test_kind_t i_test_kind;
	llc_test_stop_t o_test_stop;
	llc_ctrl_t o_ctrl;
	logic o_core_soft_rst, o_timing_gen_soft_reset, o_reg_soft_rst, o_advertising_abort, o_scan_abort;
	logic o_tx_sn, o_tx_nesn, o_sn_check_en, o_nesn_check_en, o_mic_enable, o_payload_encrypt;
	logic o_payload_decrypt, o_single_exchange, o_whiten_en, o_rx_crc_keep, o_tx_crc_zero, o_hop_remap_en;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	logic [31:0] d;

	llc_ctrl #(.RST_CYCLES(4)) dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_core_soft_rst(o_core_soft_rst),
		.o_timing_gen_soft_reset(o_timing_gen_soft_reset), .o_reg_soft_rst(o_reg_soft_rst),
		.o_advertising_abort(o_advertising_abort), .i_adv_abort_done(i_adv_abort_done),
		.o_scan_abort(o_scan_abort), .i_scan_abort_done(i_scan_abort_done), .i_test_kind(i_test_kind),
		.i_test_byte_done(i_test_byte_done), .i_test_sync_found(i_test_sync_found),
		.i_test_pkt_end(i_test_pkt_end), .o_test_stop(o_test_stop), .o_ctrl(o_ctrl),
		.i_desc_sn(i_desc_sn), .i_desc_nesn(i_desc_nesn), .i_auto_sn(i_auto_sn), .i_auto_nesn(i_auto_nesn),
		.o_tx_sn(o_tx_sn), .o_tx_nesn(o_tx_nesn), .o_sn_check_en(o_sn_check_en),
		.o_nesn_check_en(o_nesn_check_en), .i_ctrl_struct_encrypt_enable(i_ctrl_struct_encrypt_enable),
		.o_mic_enable(o_mic_enable), .o_payload_encrypt(o_payload_encrypt),
		.o_payload_decrypt(o_payload_decrypt), .o_single_exchange(o_single_exchange),
		.o_whiten_en(o_whiten_en), .o_rx_crc_keep(o_rx_crc_keep), .o_tx_crc_zero(o_tx_crc_zero),
		.o_hop_remap_en(o_hop_remap_en));

	// ****************************************
	// Clock and hang guard
	// ****************************************
	always #20 i_mclk = ~i_mclk;

	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fails = fails + 1;
			$display("mismatch at %0t: run exceeded cycle ceiling", $time);
			wrap_up();
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Master strobes change just after an edge and last one cycle
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] v);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_state();
		rd(OFF, d);
		chk(d, 32'h0000_0000, "reset read");
		chk({25'h0, o_ctrl}, 32'h0, "reset ctrl");
		chk({28'h0, o_whiten_en, o_hop_remap_en, o_sn_check_en, o_nesn_check_en}, 32'hf, "reset enables");
		$display("test reset_state done");
	endtask

	task automatic t_reserved();
		wr(OFF, 32'h18ff_ffff);
		rd(OFF, d);
		chk(d, 32'h007f_0000, "reserved bits");
		wr(OFF + 32'h4, 32'h0000_0000);
		rd(OFF, d);
		chk(d, 32'h007f_0000, "unmapped write");
		rd(OFF + 32'h4, d);
		chk(d, 32'h0000_0000, "unmapped read");
		wr(OFF, 32'h0000_0000);
		$display("test reserved done");
	endtask

	task automatic t_statics();
		logic [31:0] v;
		llc_ctrl_t c;
		for (int i = 0; i < 9; i++) begin
			v = (i < 7) ? (32'h0001_0000 << i) : ((i == 7) ? 32'h0 : 32'h007f_0000);
			c = llc_ctrl_t'(v[22:16]);
			i_ctrl_struct_encrypt_enable <= (i != 8);
			wr(OFF, v);
			@(posedge i_mclk);
			#1 chk({25'h0, o_ctrl}, {25'h0, c}, "static ctrl");
			chk({20'h0, o_single_exchange, o_whiten_en, o_rx_crc_keep, o_tx_crc_zero, o_hop_remap_en,
				o_sn_check_en, o_nesn_check_en, o_tx_sn, o_tx_nesn, o_mic_enable, o_payload_encrypt,
				o_payload_decrypt}, {20'h0, c.more_data_override, !c.whitening_disable, c.crc_strip_disable,
				c.crc_strip_disable, !c.hop_remap_disable, !c.seqnum_mgmt_disable,
				!c.next_seqnum_mgmt_disable, c.seqnum_mgmt_disable, !c.next_seqnum_mgmt_disable, i != 8,
				i != 8 && !c.encryption_disable,
				i != 8 && !c.encryption_disable}, "datapath controls");
			chk({27'h0, o_core_soft_rst, o_timing_gen_soft_reset, o_reg_soft_rst, o_advertising_abort,
				o_scan_abort}, 32'h0, "zero action write");
			rd(OFF, d);
			chk(d, v, "static readback");
		end
		$display("test statics done");
	endtask

	task automatic t_soft_rst(input int b);
		logic [31:0] keep;
		logic [31:0] one;
		keep = (b == 29) ? 32'h0 : 32'h007f_0000;
		one = 32'h1 << (b - 29);
		wr(OFF, 32'h007f_0000);
		wr(OFF, (32'h1 << b) | 32'h007f_0000);
		#1 chk({29'h0, o_core_soft_rst, o_timing_gen_soft_reset, o_reg_soft_rst}, one, "reset start");
		rd(OFF, d);
		chk(d, (32'h1 << b) | keep, "reset bit busy");
		@(posedge i_mclk);
		#1 chk({29'h0, o_core_soft_rst, o_timing_gen_soft_reset, o_reg_soft_rst}, one, "reset hold");
		@(posedge i_mclk);
		#1 chk({29'h0, o_core_soft_rst, o_timing_gen_soft_reset, o_reg_soft_rst}, 32'h0, "reset end");
		chk({25'h0, o_ctrl}, {25'h0, keep[22:16]}, "statics after reset");
		rd(OFF, d);
		chk(d, keep, "reset bit cleared");
		wr(OFF, 32'h0);
		$display("test soft reset %0d done", b);
	endtask

	task automatic t_abort(input int b);
		logic [31:0] one;
		one = 32'h1 << (b - 24);
		wr(OFF, 32'h1 << b);
		#1 chk({30'h0, o_advertising_abort, o_scan_abort}, one, "abort raised");
		repeat (3) @(posedge i_mclk);
		#1 chk({30'h0, o_advertising_abort, o_scan_abort}, one, "abort held");
		@(posedge i_mclk);
		i_adv_abort_done <= (b == 25);
		i_scan_abort_done <= (b == 24);
		@(posedge i_mclk);
		i_adv_abort_done <= 1'b0;
		i_scan_abort_done <= 1'b0;
		#1 chk({30'h0, o_advertising_abort, o_scan_abort}, 32'h0, "abort cleared");
		rd(OFF, d);
		chk(d, 32'h0, "abort bit self-clear");
		$display("test abort %0d done", b);
	endtask

	// Trigger 1 ends a byte, trigger 2 ends a packet
	task automatic t_test_abort(input llc_test_kind_t k, input logic s, input int trig, input logic [2:0] e);
		logic seen;
		seen = 1'b0;
		@(posedge i_mclk);
		i_test_kind <= k;
		i_test_sync_found <= s;
		wr(OFF, 32'h0400_0000);
		if (trig != 0 || e == 3'b000) begin
			repeat (5) begin
				@(posedge i_mclk);
				#1 chk({29'h0, o_test_stop}, 32'h0, "stop before trigger");
			end
			@(posedge i_mclk);
			i_test_byte_done <= (trig == 1);
			i_test_pkt_end <= (trig == 2);
		end
		repeat (4) begin
			@(posedge i_mclk);
			i_test_byte_done <= 1'b0;
			i_test_pkt_end <= 1'b0;
			#1 if (o_test_stop === e) seen = 1'b1;
		end
		chk({31'h0, seen}, 32'h1, "stop command");
		rd(OFF, d);
		chk(d, 32'h0, "test abort self-clear");
		$display("test radio abort kind %0d done", k);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		i_rst = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 32'h0;
		i_wdata = 32'h0;
		i_adv_abort_done = 1'b0;
		i_scan_abort_done = 1'b0;
		i_test_kind = LLC_TEST_NONE;
		i_test_byte_done = 1'b0;
		i_test_sync_found = 1'b0;
		i_test_pkt_end = 1'b0;
		// Descriptor and automatic values differ so the source is visible
		i_desc_sn = 1'b1;
		i_auto_sn = 1'b0;
		i_desc_nesn = 1'b0;
		i_auto_nesn = 1'b1;
		i_ctrl_struct_encrypt_enable = 1'b1;
		repeat (3) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		t_reset_state();
		t_reserved();
		t_statics();
		for (int b = 29; b < 32; b++)
			t_soft_rst(b);
		t_abort(25);
		t_abort(24);
		t_test_abort(LLC_TEST_NONE, 1'b0, 0, 3'b000);
		t_test_abort(LLC_TEST_INF_TX, 1'b0, 1, 3'b100);
		t_test_abort(LLC_TEST_INF_RX, 1'b0, 0, 3'b001);
		t_test_abort(LLC_TEST_INF_RX, 1'b1, 2, 3'b010);
		wrap_up();
	end
endmodule
